//--- inc/dja_pkg.sv
// Shared constants and types for the DMA job controller
`default_nettype none

package dja_pkg;

  // ==========================================================
  // Sizes
  localparam int NJOBS = 32;
  localparam int NTRIG = 64;
  localparam int NRECS = 256;
  localparam int RAMW  = 1024;
  localparam int JW    = 5;

  // ==========================================================
  // Register byte offsets
  localparam logic [12:0] OFS_LIST = 13'h0000;
  localparam logic [12:0] OFS_MAIN = 13'h0004;
  localparam logic [12:0] OFS_STAT = 13'h0008;
  localparam logic [12:0] OFS_DONE = 13'h000C;
  localparam logic [12:0] OFS_RUN  = 13'h0010;
  localparam logic [12:0] OFS_JOB  = 13'h0100;
  localparam logic [12:0] OFS_RAM  = 13'h1000;

  // ==========================================================
  // Field positions and reset values
  localparam int MC_EN    = 0;
  localparam int MC_SWRST = 1;
  localparam int MC_ERRIE = 2;
  localparam int MC_LSZ   = 8;
  localparam int ST_BUSY  = 5;
  localparam int ST_ERR   = 8;
  localparam int CT_SHOLD = 0;
  localparam int CT_DHOLD = 2;
  localparam logic [31:0] RST_MAIN = 32'h0000_0000;
  localparam logic [31:0] RST_LIST = 32'h0000_0000;
  localparam logic [31:0] RST_JOB  = 32'h0000_0000;

  // Job control word
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       sw_start;
    logic       job_en;
    logic       hw_en;
    logic       flow_en;
    logic       irq_en;
    logic       job_rst;
    logic [1:0] rsv_lo;
    logic [5:0] trig_sel;
    logic [7:0] prio;
    logic [7:0] first_rec;
  } dja_job_t;

  // Transfer record, four words, word 0 lowest
  typedef struct packed {
    logic        last;
    logic        ack_en;
    logic [11:0] rsv;
    logic [1:0]  size;
    logic [15:0] count;
    logic [31:0] ctrl;
    logic [31:0] dst;
    logic [31:0] src;
  } dja_rec_t;

endpackage

`default_nettype wire

//--- rtl/dja_arbiter.sv
// Priority picker choosing the highest-priority eligible job
`timescale 1ns/100ps
`default_nettype none

module dja_arbiter (
  input  wire logic [dja_pkg::NJOBS-1:0]      elig_i,
  input  wire logic [dja_pkg::NJOBS-1:0][7:0] prio_i,
  output logic                                win_v_o,
  output logic [dja_pkg::JW-1:0]              win_o
);

  // ==========================================================
  // Scan from the top index down; ">=" lets a lower index take a tie
  always_comb
  begin
    logic [7:0] best;
    best = 8'h00;
    win_v_o = 1'b0;
    win_o = '0;
    for (int k = dja_pkg::NJOBS - 1; k >= 0; k--)
    begin
      if (elig_i[k] && (!win_v_o || prio_i[k] >= best))
      begin
        win_v_o = 1'b1;
        win_o = dja_pkg::JW'(k);
        best = prio_i[k];
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/dja_controller.sv
// DMA job controller: register slave, record RAM, job scheduler and data mover
`timescale 1ns/100ps
`default_nettype none

// ============================================================

module dja_controller (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [12:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             m_cyc_o,
  output logic             m_stb_o,
  output logic             m_we_o,
  output logic      [31:0] m_adr_o,
  output logic      [3:0]  m_sel_o,
  output logic      [31:0] m_dat_o,
  input  wire logic [31:0] m_dat_i,
  input  wire logic        m_ack_i,
  input  wire logic        m_err_i,
  input  wire logic [63:0] hw_start_i,
  input  wire logic [31:0] dma_req_i,
  output logic      [31:0] dma_ack_o,
  input  wire logic        ecc_sbe_i,
  input  wire logic        ecc_dbe_i,
  output logic             single_bit_corrected_event_o,
  output logic             double_bit_detected_event_o,
  output logic             irq_o
);

  localparam int NJ = dja_pkg::NJOBS;
  localparam int NP = NJ + dja_pkg::NTRIG;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_RD, S_WR, S_NEXT} dja_st_t;

  dja_st_t           st_reg;
  logic [4:0]        cur_reg;
  logic [7:0]        ri_reg;
  logic [16:0]       el_reg;
  dja_pkg::dja_rec_t rec_reg;
  logic [31:0]       dat_reg;
  logic              ack_reg;
  logic [31:0]       rdat_reg;
  logic [31:0]       list_reg;
  logic [31:0]       main_reg;
  logic [NJ-1:0]     done_reg;
  logic              err_reg;
  logic              sbe_reg;
  logic              dbe_reg;
  logic [31:0]       ram_mem [dja_pkg::RAMW];
  logic [NP-1:0]     s1_reg;
  logic [NP-1:0]     s2_reg;
  logic [NP-1:0]     s3_reg;
  logic [NP-1:0]     flt_reg;
  logic [NP-1:0]     fd_reg;

  dja_pkg::dja_job_t      jc_w [NJ];
  logic [31:0]            jcw_w [NJ];
  logic [7:0]             prec_w [NJ];
  logic [16:0]            pel_w [NJ];
  logic [NJ-1:0]          run_w;
  logic [NJ-1:0]          jen_w;
  logic [NJ-1:0]          ie_w;
  logic [NJ-1:0]          start_w;
  logic [NJ-1:0][7:0]     prio_w;
  logic                   win_v;
  logic [4:0]             win;

  // ============================================================
  // Pin synchronisers: three flops, a level counts once stages 2 and 3 agree
  wire [NP-1:0] pins_w = {dma_req_i, hw_start_i};
  wire [63:0] trig_rise = flt_reg[63:0] & ~fd_reg[63:0];
  wire [NJ-1:0] req_f = flt_reg[NP-1:64];

  always_ff @(posedge clk_i)
  begin
    s1_reg <= pins_w;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
    fd_reg <= flt_reg;
  end

  // ============================================================
  // Slave decode; one wait state, unmapped reads give zero
  wire        req_v   = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        wr_v    = req_v & wb_we_i;
  wire        hit_ram = wb_adr_i[12];
  wire        hit_job = wb_adr_i[12:7] == dja_pkg::OFS_JOB[12:7];
  wire [4:0]  job_idx = wb_adr_i[6:2];
  wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        hit_lst = ~hit_ram & wb_adr_i[11:2] == dja_pkg::OFS_LIST[11:2];
  wire        hit_mn  = ~hit_ram & wb_adr_i[11:2] == dja_pkg::OFS_MAIN[11:2];
  wire        hit_st  = ~hit_ram & wb_adr_i[11:2] == dja_pkg::OFS_STAT[11:2];
  wire        hit_dn  = ~hit_ram & wb_adr_i[11:2] == dja_pkg::OFS_DONE[11:2];
  wire        hit_rn  = ~hit_ram & wb_adr_i[11:2] == dja_pkg::OFS_RUN[11:2];
  wire [31:0] wmix    = (jcw_w[job_idx] & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] wd_m    = wb_dat_i & wmask;
  wire        dma_en  = main_reg[dja_pkg::MC_EN];
  wire        sw_rst  = main_reg[dja_pkg::MC_SWRST];
  wire [7:0]  lsize   = main_reg[dja_pkg::MC_LSZ +: 8];
  wire        busy    = st_reg != S_IDLE;
  wire [31:0] stat_w  = {23'h0, err_reg, 2'h0, busy, cur_reg};

  // Read selection
  wire [31:0] rd_word = hit_ram ? ram_mem[wb_adr_i[11:2]] :
                        hit_job ? jcw_w[job_idx] :
                        hit_lst ? list_reg :
                        hit_mn  ? main_reg :
                        hit_st  ? stat_w :
                        hit_dn  ? done_reg :
                        hit_rn  ? run_w : 32'h0000_0000;

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= req_v;
      rdat_reg <= (req_v & ~wb_we_i) ? rd_word : rdat_reg;
    end
  end

  // Record RAM, written only by software; DMA writes never reach it
  always_ff @(posedge clk_i)
  begin
    if (wr_v & hit_ram)
      ram_mem[wb_adr_i[11:2]] <= (ram_mem[wb_adr_i[11:2]] & ~wmask) | wd_m;
  end

  // ============================================================
  // Engine event terms
  wire        pause   = ~win_v | (win != cur_reg);
  wire        flow_ok = ~jc_w[cur_reg].flow_en | req_f[cur_reg];
  wire        save_v  = st_reg == S_RD & ~m_cyc_o & pause;
  wire        xend    = st_reg == S_NEXT & el_reg == {1'b0, rec_reg.count};
  wire        done_v  = xend & rec_reg.last;
  wire        err_v   = m_cyc_o & m_err_i;
  wire [NJ-1:0] done_set = done_v ? (NJ'(1) << cur_reg) : '0;
  wire [7:0]  ri_inc  = ri_reg + 8'h01;
  wire [7:0]  nri     = (ri_reg == lsize - 8'h01) ? jc_w[cur_reg].first_rec : ri_inc;
  wire [9:0]  rw      = list_reg[9:0] + {ri_reg, 2'b00};
  wire [127:0] fetch_w = {ram_mem[rw + 10'd3], ram_mem[rw + 10'd2], ram_mem[rw + 10'd1], ram_mem[rw]};

  // Element addressing; size code 3 is treated as a word
  wire [1:0]  sz      = (rec_reg.size == 2'd3) ? 2'd2 : rec_reg.size;
  wire [18:0] off     = {2'b00, el_reg} << sz;
  wire [31:0] src_a   = rec_reg.ctrl[dja_pkg::CT_SHOLD] ? rec_reg.src : rec_reg.src + {13'h0, off};
  wire [31:0] dst_a   = rec_reg.ctrl[dja_pkg::CT_DHOLD] ? rec_reg.dst : rec_reg.dst + {13'h0, off};
  wire [3:0]  lanes   = (sz == 2'd0) ? 4'h1 : (sz == 2'd1) ? 4'h3 : 4'hF;
  wire [31:0] elem    = m_dat_i >> {src_a[1:0], 3'b000};

  assign m_stb_o = m_cyc_o;

  // ============================================================
  // Job priority selection
  dja_arbiter u_arb (
    .elig_i  (run_w & jen_w & {NJ{dma_en & ~sw_rst}}),
    .prio_i  (prio_w),
    .win_v_o (win_v),
    .win_o   (win)
  );

  // ============================================================
  // Data mover: fetch record, then one read and one write per element
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= S_IDLE;
      cur_reg <= 5'h00;
      ri_reg <= 8'h00;
      el_reg <= 17'h00000;
      rec_reg <= '0;
      dat_reg <= 32'h0000_0000;
      m_cyc_o <= 1'b0;
      m_we_o <= 1'b0;
      m_adr_o <= 32'h0000_0000;
      m_sel_o <= 4'h0;
      m_dat_o <= 32'h0000_0000;
    end
    else
    begin
      unique case (st_reg)
        S_IDLE:
          if (win_v)
          begin
            cur_reg <= win;
            ri_reg <= prec_w[win];
            el_reg <= pel_w[win];
            st_reg <= S_FETCH;
          end
        S_FETCH:
        begin
          rec_reg <= fetch_w;
          st_reg <= S_RD;
        end
        S_RD:
          if (m_cyc_o)
          begin
            m_cyc_o <= ~(m_ack_i | m_err_i);
            dat_reg <= m_ack_i ? elem : dat_reg;
            st_reg <= m_err_i ? S_IDLE : m_ack_i ? S_WR : S_RD;
          end
          else if (pause)
            st_reg <= S_IDLE;
          else if (flow_ok)
          begin
            m_cyc_o <= 1'b1;
            m_we_o <= 1'b0;
            m_adr_o <= {src_a[31:2], 2'b00};
            m_sel_o <= lanes << src_a[1:0];
          end
        S_WR:
          if (m_cyc_o)
          begin
            m_cyc_o <= ~(m_ack_i | m_err_i);
            st_reg <= m_err_i ? S_IDLE : m_ack_i ? S_NEXT : S_WR;
          end
          else
          begin
            m_cyc_o <= 1'b1;
            m_we_o <= 1'b1;
            m_adr_o <= {dst_a[31:2], 2'b00};
            m_sel_o <= lanes << dst_a[1:0];
            m_dat_o <= dat_reg << {dst_a[1:0], 3'b000};
          end
        S_NEXT:
          if (xend)
          begin
            ri_reg <= nri;
            el_reg <= 17'h00000;
            st_reg <= rec_reg.last ? S_IDLE : S_FETCH;
          end
          else
          begin
            el_reg <= el_reg + 17'h00001;
            st_reg <= S_RD;
          end
      endcase
    end
  end

  // ============================================================
  // Global registers; a hardware set beats a software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      list_reg <= dja_pkg::RST_LIST;
      main_reg <= dja_pkg::RST_MAIN;
      done_reg <= '0;
      err_reg <= 1'b0;
      sbe_reg <= 1'b0;
      dbe_reg <= 1'b0;
    end
    else
    begin
      list_reg <= (wr_v & hit_lst) ? (list_reg & ~wmask) | wd_m : list_reg;
      main_reg <= (wr_v & hit_mn) ? (main_reg & ~wmask) | wd_m : main_reg;
      done_reg <= done_set | (done_reg & ~((wr_v & hit_dn) ? wd_m : 32'h0000_0000));
      err_reg <= err_v | (err_reg & ~(wr_v & hit_st & wd_m[dja_pkg::ST_ERR]));
      sbe_reg <= ecc_sbe_i;
      dbe_reg <= ecc_dbe_i;
    end
  end

  assign single_bit_corrected_event_o = sbe_reg;
  assign double_bit_detected_event_o = dbe_reg;
  assign irq_o = |(done_reg & ie_w) | (err_reg & main_reg[dja_pkg::MC_ERRIE]);

  // ============================================================
  // Per-job control, run flag, saved progress and acknowledge
  for (genvar j = 0; j < NJ; j++)
  begin : g_job
    dja_pkg::dja_job_t jc_reg;
    dja_pkg::dja_job_t nw;
    logic              run_reg;
    logic              ack_q;
    logic [7:0]        prec_reg;
    logic [16:0]       pel_reg;
    wire               me    = cur_reg == 5'(j);
    wire               wr_me = wr_v & hit_job & (job_idx == 5'(j));
    wire               sw_st = wr_me & nw.sw_start & ~nw.hw_en & ~sw_rst;
    wire               hw_st = jc_reg.hw_en & trig_rise[jc_reg.trig_sel] & ~sw_rst;
    wire               st_ev = sw_st | hw_st;
    wire               kill  = sw_rst | (wr_me & nw.job_rst) | ((done_v | err_v) & me);

    assign nw = wmix;
    assign jc_w[j] = jc_reg;
    assign jcw_w[j] = jc_reg;
    assign prec_w[j] = prec_reg;
    assign pel_w[j] = pel_reg;
    assign run_w[j] = run_reg;
    assign jen_w[j] = jc_reg.job_en;
    assign ie_w[j] = jc_reg.irq_en;
    assign prio_w[j] = jc_reg.prio;
    assign start_w[j] = st_ev;
    assign dma_ack_o[j] = ack_q;

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        jc_reg <= dja_pkg::RST_JOB;
        run_reg <= 1'b0;
        prec_reg <= 8'h00;
        pel_reg <= 17'h00000;
        ack_q <= 1'b0;
      end
      else
      begin
        jc_reg <= wr_me ? {nw[31:30], 1'b0, nw[28:25], 1'b0, nw[23:0]} : jc_reg;
        run_reg <= st_ev | (run_reg & ~kill);
        prec_reg <= st_ev ? (wr_me ? nw.first_rec : jc_reg.first_rec) : (save_v & me) ? ri_reg : prec_reg;
        pel_reg <= st_ev ? 17'h00000 : (save_v & me) ? el_reg : pel_reg;
        ack_q <= req_f[j] & (ack_q | (xend & me & rec_reg.ack_en & jc_reg.flow_en));
      end
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence fetch_seq;
    st_reg == S_FETCH ##1 st_reg == S_RD;
  endsequence

  bus_one_wait_a: assert property (req_v |=> wb_ack_o ##1 !wb_ack_o)
    else $error("slave ack not a single cycle after request");
  pick_then_fetch_a: assert property (st_reg == S_IDLE && win_v |=> cur_reg == $past(win) ##0 fetch_seq)
    else $error("picked job not fetched");
  master_hold_a: assert property (m_cyc_o && !m_ack_i && !m_err_i |=> m_cyc_o && $stable(m_adr_o))
    else $error("master request dropped before answer");
  flow_wait_a: assert property (st_reg == S_RD && !m_cyc_o && !pause && !flow_ok |=> !m_cyc_o)
    else $error("transfer issued without peripheral request");
  last_done_a: assert property (done_v && !start_w[cur_reg] |=> !run_w[$past(cur_reg)] && done_reg[$past(cur_reg)])
    else $error("last record did not finish job");
  loop_back_a: assert property (xend && !rec_reg.last |=> st_reg == S_FETCH)
    else $error("job without last record stopped");
  preempt_save_a: assert property (save_v |=> st_reg == S_IDLE && prec_w[$past(cur_reg)] == $past(ri_reg))
    else $error("suspended job progress not saved");
  ack_drop_a: assert property (!req_f[5] |=> !dma_ack_o[5])
    else $error("acknowledge held without request");
  halt_idle_a: assert property (!dma_en && st_reg == S_IDLE |=> st_reg == S_IDLE)
    else $error("engine ran while globally disabled");

endmodule

`default_nettype wire

//--- tb/dja_mem_model.sv
// Behavioural memory slave standing on the far side of the master port
`timescale 1ns/100ps
`default_nettype none

module dja_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  dly_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o
);
  // ==========================================================
  // Storage, decode and wait counter
  logic [31:0] mem [0:255];
  logic [31:0] rd_reg;
  logic [3:0]  wait_reg;
  wire         req = cyc_i && stb_i && !ack_o && !err_o;
  wire  [7:0]  idx = adr_i[9:2];
  wire         bad = (adr_i[31:28] == 4'hF);

  // Answer after dly_i wait cycles; the top nibble F stands for a bus fault
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    if (rst_i)
      wait_reg <= 4'h0;
    else if (req && wait_reg >= dly_i)
    begin
      wait_reg <= 4'h0;
      err_o    <= bad;
      ack_o    <= !bad;
      rd_reg   <= mem[idx];
      for (int b = 0; b < 4; b++)
        if (we_i && !bad && sel_i[b])
          mem[idx][8*b +: 8] <= dat_i[8*b +: 8];
    end
    else if (req)
      wait_reg <= wait_reg + 4'h1;
  end

  // Outside the answer the lines show the inverse, so stale data never passes
  assign dat_o = ack_o ? rd_reg : ~rd_reg;
endmodule

`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the DMA job controller
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [12:0] adr   = 13'h0000;
  logic [31:0] wdat  = 32'h0;
  logic [63:0] hw    = 64'h0;
  logic [31:0] req   = 32'h0;
  logic        sbe   = 1'b0;
  logic        dbe   = 1'b0;
  logic [3:0]  dly   = 4'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        m_cyc;
  logic        m_stb;
  logic        m_we;
  logic [31:0] m_adr;
  logic [3:0]  m_sel;
  logic [31:0] m_dato;
  logic [31:0] m_dati;
  logic        m_ack;
  logic        m_err;
  logic [31:0] dack;
  logic [1:0]  ev;
  logic        irq;
  logic [31:0] q;
  logic [31:0] e;
  logic [31:0] first_wr;
  logic        grab  = 1'b0;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          nwr = 0;

  always #2 clk_i = ~clk_i;

  // ==========================================================
  // Device and far-side memory
  dja_controller dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .m_cyc_o(m_cyc), .m_stb_o(m_stb), .m_we_o(m_we), .m_adr_o(m_adr), .m_sel_o(m_sel),
    .m_dat_o(m_dato), .m_dat_i(m_dati), .m_ack_i(m_ack), .m_err_i(m_err), .hw_start_i(hw),
    .dma_req_i(req), .dma_ack_o(dack), .ecc_sbe_i(sbe), .ecc_dbe_i(dbe),
    .single_bit_corrected_event_o(ev[0]), .double_bit_detected_event_o(ev[1]), .irq_o(irq));

  dja_mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(m_cyc), .stb_i(m_stb), .we_i(m_we),
    .adr_i(m_adr), .sel_i(m_sel), .dat_i(m_dato), .dly_i(dly), .dat_o(m_dati), .ack_o(m_ack),
    .err_o(m_err));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] pat(input int i);
    return 32'h5A5A_0000 | i;
  endfunction

  function automatic logic [31:0] jw(input logic sw, hwe, fl, input logic [5:0] tr, input logic [7:0] pr, fr);
    dja_pkg::dja_job_t j;
    j = '0;
    j.sw_start = sw;
    j.hw_en = hwe;
    j.flow_en = fl;
    j.trig_sel = tr;
    j.prio = pr;
    j.first_rec = fr;
    j.job_en = 1'b1;
    j.irq_en = 1'b1;
    return j;
  endfunction

  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic single cycle: held until ack is sampled, released after it
  task automatic wb(input logic w, input logic [12:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
      chk(32'h0, 32'h1, "bus ack missing");
  endtask

  task automatic rd(input logic [12:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask

  task automatic put_rec(input logic [7:0] r, input logic [31:0] s, d, w3);
    wb(1'b1, dja_pkg::OFS_RAM + {1'b0, r, 4'h0}, s);
    wb(1'b1, dja_pkg::OFS_RAM + {1'b0, r, 4'h4}, d);
    wb(1'b1, dja_pkg::OFS_RAM + {1'b0, r, 4'h8}, 32'h0);
    wb(1'b1, dja_pkg::OFS_RAM + {1'b0, r, 4'hC}, w3);
  endtask

  // Polls the sticky done mask, then clears it
  task automatic wait_done(input logic [31:0] m);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, dja_pkg::OFS_DONE, 32'h0);
      n++;
    end
    while ((q & m) !== m && n < 300);
    chk(q & m, m, "job done");
    chk({31'h0, irq}, 32'h1, "done irq");
    wb(1'b1, dja_pkg::OFS_DONE, m);
  endtask

  // Master write counter, first write address and hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (m_cyc && m_we && m_ack)
      nwr++;
    if (grab && m_cyc && m_we)
    begin
      first_wr = m_adr;
      grab = 1'b0;
    end
    if (cycles == 30000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    for (int i = 0; i < 256; i++)
      mdl.mem[i] = pat(i);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(dja_pkg::OFS_MAIN, dja_pkg::RST_MAIN, "main reset");
    rd(dja_pkg::OFS_LIST, dja_pkg::RST_LIST, "list reset");
    rd(dja_pkg::OFS_JOB + 13'h07C, dja_pkg::RST_JOB, "job31 reset");
    wb(1'b1, 13'h0040, 32'hFFFF_FFFF);
    rd(13'h0040, 32'h0, "unmapped");
    wb(1'b1, dja_pkg::OFS_JOB + 13'h01C, 32'h3F3F_7F05);
    rd(dja_pkg::OFS_JOB + 13'h01C, 32'h1E3F_7F05, "job word");
    wb(1'b1, dja_pkg::OFS_JOB + 13'h01C, 32'h0);
    wb(1'b1, dja_pkg::OFS_MAIN, 32'h0000_0005);
    put_rec(8'h00, 32'h0000_0100, 32'h0000_0200, 32'h8002_0001);
    put_rec(8'h01, 32'h0000_0101, 32'h0000_0283, 32'h8000_0000);
    put_rec(8'h02, 32'h0000_0300, 32'h0000_0000, 32'h8002_0013);
    put_rec(8'h03, 32'h0000_0100, 32'h0000_03FC, 32'h8002_0000);
    put_rec(8'h04, 32'h0000_0104, 32'h0000_0204, 32'h8002_0000);
    put_rec(8'h05, 32'h0000_0108, 32'h0000_0208, 32'hC002_0000);
    put_rec(8'h06, 32'hF000_0000, 32'h0000_020C, 32'h8002_0000);
    rd(dja_pkg::OFS_RAM + 13'h001C, 32'h8000_0000, "ram word");
    // Two words by software start, then the done interrupt
    wb(1'b1, dja_pkg::OFS_JOB, jw(1, 0, 0, 6'h00, 8'h01, 8'h00));
    wait_done(32'h1);
    chk(mdl.mem[8'h80], pat(8'h40), "word 0");
    chk(mdl.mem[8'h81], pat(8'h41), "word 1");
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // One byte moved from lane 1 to lane 3
    wb(1'b1, dja_pkg::OFS_JOB + 13'h004, jw(1, 0, 0, 6'h00, 8'h01, 8'h01));
    wait_done(32'h2);
    e = pat(8'h40);
    chk(mdl.mem[8'hA0], {e[15:8], 24'h0} | (pat(8'hA0) & 32'h00FF_FFFF), "byte lane");
    // Equal priority: the smaller job number goes first
    wb(1'b1, dja_pkg::OFS_MAIN, 32'h0000_0004);
    wb(1'b1, dja_pkg::OFS_JOB, jw(1, 0, 0, 6'h00, 8'h01, 8'h00));
    wb(1'b1, dja_pkg::OFS_JOB + 13'h004, jw(1, 0, 0, 6'h00, 8'h01, 8'h01));
    rd(dja_pkg::OFS_RUN, 32'h3, "started mask");
    grab = 1'b1;
    wb(1'b1, dja_pkg::OFS_MAIN, 32'h0000_0005);
    wait_done(32'h3);
    chk(first_wr, 32'h0000_0200, "first job");
    // Slow memory; a high-priority job preempts a long one
    dly <= 4'h3;
    nwr = 0;
    wb(1'b1, dja_pkg::OFS_JOB + 13'h008, jw(1, 0, 0, 6'h00, 8'h01, 8'h02));
    repeat (40) @(posedge clk_i);
    wb(1'b1, dja_pkg::OFS_JOB + 13'h00C, jw(1, 0, 0, 6'h00, 8'h09, 8'h03));
    wait_done(32'h8);
    rd(dja_pkg::OFS_DONE, 32'h0, "low job still open");
    wait_done(32'h4);
    chk(nwr, 32'd21, "write count");
    for (int i = 0; i < 20; i++)
      chk(mdl.mem[i], pat(8'hC0 + i), "resumed copy");
    dly <= 4'h0;
    // Trigger 5 starts job 4 only once its enable is set
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, dja_pkg::OFS_JOB + 13'h010, jw(0, k[0], 0, 6'h05, 8'h01, 8'h04));
      hw[5] <= 1'b1;
      repeat (8) @(posedge clk_i);
      hw[5] <= 1'b0;
      repeat (40) @(posedge clk_i);
      rd(dja_pkg::OFS_DONE, k ? 32'h10 : 32'h0, "hw start");
    end
    wb(1'b1, dja_pkg::OFS_DONE, 32'h10);
    // Flow check holds job 5 until its request, then acknowledges
    wb(1'b1, dja_pkg::OFS_JOB + 13'h014, jw(1, 0, 1, 6'h00, 8'h01, 8'h05));
    repeat (40) @(posedge clk_i);
    rd(dja_pkg::OFS_DONE, 32'h0, "waits on request");
    req[5] <= 1'b1;
    wait_done(32'h20);
    repeat (6) @(posedge clk_i);
    chk({31'h0, dack[5]}, 32'h1, "ack high");
    req[5] <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(dack, 32'h0, "ack low");
    // Soft reset cancels a waiting job and blocks new starts
    wb(1'b1, dja_pkg::OFS_JOB + 13'h014, jw(1, 0, 1, 6'h00, 8'h01, 8'h05));
    wb(1'b1, dja_pkg::OFS_MAIN, 32'h0000_0003);
    rd(dja_pkg::OFS_RUN, 32'h0, "soft reset cancels");
    wb(1'b1, dja_pkg::OFS_JOB + 13'h014, jw(1, 0, 1, 6'h00, 8'h01, 8'h05));
    rd(dja_pkg::OFS_RUN, 32'h0, "start blocked");
    rd(dja_pkg::OFS_STAT, 32'h0000_0005, "engine idle");
    wb(1'b1, dja_pkg::OFS_MAIN, 32'h0000_0001);
    // Bus fault with the error interrupt masked, then enabled
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, dja_pkg::OFS_MAIN, k ? 32'h0000_0005 : 32'h0000_0001);
      wb(1'b1, dja_pkg::OFS_JOB + 13'h018, jw(1, 0, 0, 6'h00, 8'h01, 8'h06));
      repeat (30) @(posedge clk_i);
      rd(dja_pkg::OFS_STAT, 32'h0000_0106, "error flag");
      chk({31'h0, irq}, k, "error irq");
      wb(1'b1, dja_pkg::OFS_STAT, 32'h0000_0100);
    end
    rd(dja_pkg::OFS_DONE, 32'h0, "no done on fault");
    // Memory correction events pass on one cycle later
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      sbe <= (k == 0);
      dbe <= (k == 1);
      @(posedge clk_i);
      sbe <= 1'b0;
      dbe <= 1'b0;
      @(posedge clk_i);
      chk({30'h0, ev}, k ? 32'h2 : 32'h1, "ecc event");
    end
    give_verdict();
  end
endmodule

`default_nettype wire
